// File: common/jdp_pkg.sv
// constants, field layouts and state types of the jtag debug and id port
package jdp_pkg;
  // instruction register
  localparam int IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_DEVICE_IDENTIFICATION = 4'h1;
  localparam logic [3:0] IR_USERCODE = 4'h2;
  localparam logic [3:0] IR_SAMPLE = 4'h3;
  localparam logic [3:0] IR_DEBUG = 4'h4;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;
  // data register width and id field layout
  localparam int DR_W = 32;
  localparam int ID_VER_W = 4;
  localparam int ID_PART_W = 16;
  localparam int ID_MFR_W = 11;
  localparam logic ID_FIXED_LSB = 1'b1;
  // user code layout
  localparam int USR_UID_W = 10;
  localparam int USR_UNUSED_W = 6;
  localparam int USR_REV_W = 16;
  // security register bits
  localparam int SEC_W = 32;
  localparam int SEC_JTAG_OFF = 0;
  localparam int SEC_DEBUG_OFF = 14;
  localparam int SEC_UID_LSB = 22;
  localparam int SEC_UID_MSB = 31;
  // board-side reset hold times
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRST_MIN_NS = 100;
  localparam int TRST_MIN_CYC = (TRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_MIN_NS = 100;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // boot mode pins
  localparam int BM_W = 2;
  typedef enum logic [3:0] {
    TS_RESET = 4'h0, TS_IDLE = 4'h1, TS_SEL_DR = 4'h2, TS_CAP_DR = 4'h3,
    TS_SH_DR = 4'h4, TS_EX1_DR = 4'h5, TS_PA_DR = 4'h6, TS_EX2_DR = 4'h7,
    TS_UPD_DR = 4'h8, TS_SEL_IR = 4'h9, TS_CAP_IR = 4'hA, TS_SH_IR = 4'hB,
    TS_EX1_IR = 4'hC, TS_PA_IR = 4'hD, TS_EX2_IR = 4'hE, TS_UPD_IR = 4'hF
  } jdp_tap_state_t;
  typedef enum logic [1:0] {
    RS_HELD = 2'h0, RS_LOCK = 2'h1, RS_RUN = 2'h2
  } jdp_rst_state_t;
endpackage

// File: common/jdp_tap_if.sv
// signals between the top and one tap controller
`timescale 1ns/100ps
interface jdp_tap_if;
  import jdp_pkg::*;
  logic tck_rise;
  logic tms;
  logic tdi;
  logic trst;
  jdp_tap_state_t state;
  logic [IR_W-1:0] ir;
  logic ir_out;
  logic capture_dr;
  logic shift_dr;
  logic update_dr;
  modport ctl (output tck_rise, tms, tdi, trst,
               input state, ir, ir_out, capture_dr, shift_dr, update_dr);
  modport tap (input tck_rise, tms, tdi, trst,
               output state, ir, ir_out, capture_dr, shift_dr, update_dr);
endinterface

// File: verilog/jdp_tap.sv
// tap controller state machine and instruction register
`timescale 1ns/100ps
module jdp_tap
  import jdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  jdp_tap_if.tap t
);
  jdp_tap_state_t state, next_state;
  logic [IR_W-1:0] ir_sh, next_ir_sh;
  logic [IR_W-1:0] ir, next_ir;

  // state walk on each tck rising edge, test reset acts on the next clk edge without waiting for tck
  always_comb begin
    next_state = state;
    next_ir_sh = ir_sh;
    next_ir = ir;
    if (t.trst) begin
      next_state = TS_RESET; // R15
      next_ir = IR_DEVICE_IDENTIFICATION;
    end else if (t.tck_rise) begin // R15
      unique case (state)
        TS_RESET: next_state = t.tms ? TS_RESET : TS_IDLE;
        TS_IDLE: next_state = t.tms ? TS_SEL_DR : TS_IDLE;
        TS_SEL_DR: next_state = t.tms ? TS_SEL_IR : TS_CAP_DR;
        TS_CAP_DR: next_state = t.tms ? TS_EX1_DR : TS_SH_DR;
        TS_SH_DR: next_state = t.tms ? TS_EX1_DR : TS_SH_DR;
        TS_EX1_DR: next_state = t.tms ? TS_UPD_DR : TS_PA_DR;
        TS_PA_DR: next_state = t.tms ? TS_EX2_DR : TS_PA_DR;
        TS_EX2_DR: next_state = t.tms ? TS_UPD_DR : TS_SH_DR;
        TS_UPD_DR: next_state = t.tms ? TS_SEL_DR : TS_IDLE;
        TS_SEL_IR: next_state = t.tms ? TS_RESET : TS_CAP_IR;
        TS_CAP_IR: next_state = t.tms ? TS_EX1_IR : TS_SH_IR;
        TS_SH_IR: next_state = t.tms ? TS_EX1_IR : TS_SH_IR;
        TS_EX1_IR: next_state = t.tms ? TS_UPD_IR : TS_PA_IR;
        TS_PA_IR: next_state = t.tms ? TS_EX2_IR : TS_PA_IR;
        TS_EX2_IR: next_state = t.tms ? TS_UPD_IR : TS_SH_IR;
        TS_UPD_IR: next_state = t.tms ? TS_SEL_DR : TS_IDLE;
      endcase
      if (state == TS_RESET) begin
        next_ir = IR_DEVICE_IDENTIFICATION; // R1
      end
      if (state == TS_CAP_IR) begin
        next_ir_sh = IR_CAPTURE_VAL; // R2
      end
      if (state == TS_SH_IR) begin
        next_ir_sh = {t.tdi, ir_sh[IR_W-1:1]};
      end
      if (state == TS_UPD_IR) begin
        next_ir = ir_sh;
      end
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= TS_RESET;
      ir_sh <= IR_CAPTURE_VAL;
      ir <= IR_DEVICE_IDENTIFICATION; // R1
    end else begin
      state <= next_state;
      ir_sh <= next_ir_sh;
      ir <= next_ir;
    end
  end

  // strobes for the data registers held by the top
  assign t.state = state;
  assign t.ir = ir;
  assign t.ir_out = ir_sh[0];
  assign t.capture_dr = t.tck_rise && !t.trst && state == TS_CAP_DR;
  assign t.shift_dr = t.tck_rise && !t.trst && state == TS_SH_DR;
  assign t.update_dr = t.tck_rise && !t.trst && state == TS_UPD_DR;
endmodule // jdp_tap

// File: verilog/jdp_top.sv
// jtag chain, id and user code, debug sync pin and global reset sequencing
// What this block does
// R1: after reset, boundary and chip taps chained
// R2: boundary tap scans the i/o pins
// R3: chip tap reaches tile, switch and otp
// R4: host holds test reset low 100 ns
// R5: test reset low keeps jtag in reset
// R6: debug pin floats until breakpoint, then low
// R7: external low on debug pin enters debug
// R8: software picks debug pin direction and use
// R9: device_identification selects 32-bit id, lsb one
// R10: usercode selects uid, unused, revision word
// R11: uid from security bits 31:22
// R12: global reset low acts at once; the code acts on the third clk edge, after the two-flop synchroniser
// R13: after reset wait pll lock, then boot
// R14: board holds global reset low 100 ns
// R15: tap moves on tck, test reset asynchronous; the code passes test reset through the two-flop synchroniser to clk
// R16: security bit 0 disables chip access
// R17: id layout version, part, manufacturer, one
`timescale 1ns/100ps
module jdp_top
  import jdp_pkg::*;
#(
  parameter int BSR_W = 8,
  parameter logic [ID_VER_W-1:0] ID_VERSION = 4'h1, // arbitrary value
  parameter logic [ID_PART_W-1:0] ID_PART = 16'h5A5A, // arbitrary value
  parameter logic [ID_MFR_W-1:0] ID_MFR = 11'h155, // arbitrary value
  parameter logic [USR_REV_W-1:0] SI_REVISION = 16'h0001 // arbitrary value
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  input wire logic TRST_N,
  output logic TDO,
  output logic TDO_OE_N,
  input wire logic [SEC_W-1:0] SECURITY,
  input wire logic [BSR_W-1:0] PIN_IN,
  output logic [BSR_W-1:0] PIN_OUT,
  output logic EXTEST_ON,
  input wire logic [DR_W-1:0] DBG_RDATA,
  output logic [DR_W-1:0] DBG_WDATA,
  output logic DBG_WSTROBE,
  input wire logic DBG_PIN_EN,
  input wire logic DBG_PIN_DIR,
  input wire logic BREAKPOINT_HIT,
  input wire logic DEBUG_N_IN,
  output logic DEBUG_N_OUT,
  output logic DEBUG_N_OE_N,
  output logic DEBUG_ENTER,
  input wire logic RST_N,
  input wire logic PLL_LOCK,
  input wire logic [BM_W-1:0] BOOT_MODE,
  output logic CORE_RESET_N,
  output logic PLL_RELOCK,
  output logic BOOT_START,
  output logic [BM_W-1:0] BOOT_MODE_SEL
);
  localparam int SY_W = 7 + BM_W + BSR_W;
  localparam int DR_IW = $clog2(DR_W);
  localparam logic [SY_W-1:0] SY_IDLE = SY_W'(1) << (BM_W + BSR_W); // sync line idles high

  // two-flop synchronisers for every pin input
  logic [SY_W-1:0] sy1, sy2;
  logic tck_s, tms_s, tdi_s, trst_n_s, rst_n_s, pll_s, dbg_n_s, tck_d;
  logic [BM_W-1:0] bm_s;
  logic [BSR_W-1:0] pin_s;
  always_ff @(posedge CLK) begin
    if (RST) begin
      sy1 <= SY_IDLE;
      sy2 <= SY_IDLE;
      tck_d <= 1'b0;
    end else begin
      sy1 <= {TCK, TMS, TDI, TRST_N, RST_N, PLL_LOCK, DEBUG_N_IN, BOOT_MODE, PIN_IN};
      sy2 <= sy1;
      tck_d <= tck_s;
    end
  end
  assign {tck_s, tms_s, tdi_s, trst_n_s, rst_n_s, pll_s, dbg_n_s, bm_s, pin_s} = sy2;

  // tck edges and the two taps of the chain
  logic tck_rise, tck_fall, trst;
  assign tck_rise = tck_s && !tck_d;
  assign tck_fall = !tck_s && tck_d;
  assign trst = !trst_n_s; // R5
  jdp_tap_if bt ();
  jdp_tap_if ct ();
  logic b_out, c_out;
  assign bt.tck_rise = tck_rise;
  assign bt.tms = tms_s;
  assign bt.tdi = tdi_s;
  assign bt.trst = trst;
  assign ct.tck_rise = tck_rise;
  assign ct.tms = tms_s;
  assign ct.tdi = b_out; // R1
  assign ct.trst = trst;
  jdp_tap u_btap (
    .clk(CLK),
    .rst(RST),
    .t(bt)
  );
  jdp_tap u_ctap (
    .clk(CLK),
    .rst(RST),
    .t(ct)
  );

  // register contents and instruction decode
  logic [DR_W-1:0] id_word, usr_word;
  logic [IR_W-1:0] c_ir;
  logic secured;
  assign id_word = {ID_VERSION, ID_PART, ID_MFR, ID_FIXED_LSB}; // R9 R17
  assign usr_word = {SECURITY[SEC_UID_MSB:SEC_UID_LSB], {USR_UNUSED_W{1'b0}}, SI_REVISION}; // R10 R11
  assign secured = SECURITY[SEC_JTAG_OFF];
  assign c_ir = secured ? IR_BYPASS : ct.ir; // R16

  // data registers of both taps
  logic [DR_W-1:0] b_dr, next_b_dr, c_dr, next_c_dr;
  logic [DR_IW-1:0] b_msb, c_msb;
  logic b_bsr;
  assign b_bsr = bt.ir == IR_SAMPLE || bt.ir == IR_EXTEST;
  always_comb begin
    b_msb = '0;
    if (bt.ir == IR_DEVICE_IDENTIFICATION) begin
      b_msb = DR_IW'(DR_W - 1);
    end else if (b_bsr) begin
      b_msb = DR_IW'(BSR_W - 1); // R2
    end
    c_msb = '0;
    if (c_ir == IR_DEVICE_IDENTIFICATION || c_ir == IR_USERCODE || c_ir == IR_DEBUG) begin
      c_msb = DR_IW'(DR_W - 1); // R3
    end
  end
  always_comb begin
    next_b_dr = b_dr;
    if (bt.capture_dr) begin
      next_b_dr = '0;
      if (bt.ir == IR_DEVICE_IDENTIFICATION) begin
        next_b_dr = id_word; // R9
      end else if (b_bsr) begin
        next_b_dr = DR_W'(pin_s); // R2
      end
    end else if (bt.shift_dr) begin
      next_b_dr = b_dr >> 1;
      next_b_dr[b_msb] = tdi_s;
    end
    next_c_dr = c_dr;
    if (ct.capture_dr) begin
      next_c_dr = '0;
      unique case (c_ir)
        IR_DEVICE_IDENTIFICATION: next_c_dr = id_word; // R9
        IR_USERCODE: next_c_dr = usr_word; // R10
        IR_DEBUG: next_c_dr = DBG_RDATA; // R3
        default: next_c_dr = '0;
      endcase
    end else if (ct.shift_dr) begin
      next_c_dr = c_dr >> 1;
      next_c_dr[c_msb] = b_out;
    end
  end

  // serial outputs of each tap into the chain
  always_comb begin
    b_out = (bt.state == TS_SH_IR) ? bt.ir_out : b_dr[0];
    c_out = (ct.state == TS_SH_IR) ? ct.ir_out : c_dr[0];
  end

  // update side effects of both taps
  logic [BSR_W-1:0] next_pin_out;
  logic next_extest, next_wstrobe, next_tdo, next_tdo_oe_n;
  logic [DR_W-1:0] next_wdata;
  always_comb begin
    next_pin_out = PIN_OUT;
    next_extest = (bt.ir == IR_EXTEST) && !trst; // R2
    next_wdata = DBG_WDATA;
    next_wstrobe = 1'b0;
    next_tdo = TDO;
    next_tdo_oe_n = TDO_OE_N;
    if (bt.update_dr && b_bsr) begin
      next_pin_out = b_dr[BSR_W-1:0]; // R2
    end
    if (ct.update_dr && c_ir == IR_DEBUG) begin
      next_wdata = c_dr; // R3
      next_wstrobe = 1'b1;
    end
    if (trst) begin
      next_tdo_oe_n = 1'b1; // R5
    end else if (tck_fall) begin
      next_tdo = c_out;
      next_tdo_oe_n = !(ct.state == TS_SH_DR || ct.state == TS_SH_IR);
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      b_dr <= '0;
      c_dr <= '0;
      PIN_OUT <= '0;
      EXTEST_ON <= 1'b0;
      DBG_WDATA <= '0;
      DBG_WSTROBE <= 1'b0;
      TDO <= 1'b0;
      TDO_OE_N <= 1'b1;
    end else begin
      b_dr <= next_b_dr;
      c_dr <= next_c_dr;
      PIN_OUT <= next_pin_out;
      EXTEST_ON <= next_extest;
      DBG_WDATA <= next_wdata;
      DBG_WSTROBE <= next_wstrobe;
      TDO <= next_tdo;
      TDO_OE_N <= next_tdo_oe_n;
    end
  end

  // debug sync pin, direction and use set by software
  logic dbg_ok, next_dbg_oe_n, next_dbg_enter;
  always_comb begin
    dbg_ok = DBG_PIN_EN && !SECURITY[SEC_DEBUG_OFF]; // R8
    next_dbg_oe_n = !(dbg_ok && DBG_PIN_DIR && BREAKPOINT_HIT); // R6
    next_dbg_enter = dbg_ok && !DBG_PIN_DIR && !dbg_n_s; // R7
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      DEBUG_N_OUT <= 1'b0;
      DEBUG_N_OE_N <= 1'b1;
      DEBUG_ENTER <= 1'b0;
    end else begin
      DEBUG_N_OUT <= 1'b0;
      DEBUG_N_OE_N <= next_dbg_oe_n;
      DEBUG_ENTER <= next_dbg_enter;
    end
  end

  // global reset, pll relock, then boot
  jdp_rst_state_t rs, next_rs;
  logic [BM_W-1:0] next_bm_sel;
  always_comb begin
    next_rs = rs;
    next_bm_sel = BOOT_MODE_SEL;
    if (!rst_n_s) begin
      next_rs = RS_HELD; // R12
    end else begin
      unique case (rs)
        RS_HELD: next_rs = RS_LOCK;
        RS_LOCK: begin
          if (pll_s) begin
            next_rs = RS_RUN; // R13
            next_bm_sel = bm_s;
          end
        end
        RS_RUN: next_rs = RS_RUN;
        default: next_rs = RS_HELD;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      rs <= RS_HELD;
      CORE_RESET_N <= 1'b0;
      PLL_RELOCK <= 1'b0;
      BOOT_START <= 1'b0;
      BOOT_MODE_SEL <= '0;
    end else begin
      rs <= next_rs;
      CORE_RESET_N <= next_rs == RS_RUN;
      PLL_RELOCK <= next_rs == RS_LOCK;
      BOOT_START <= next_rs == RS_RUN && rs == RS_LOCK; // R13
      BOOT_MODE_SEL <= next_bm_sel;
    end
  end
endmodule // jdp_top

// File: dv/jdp_host.sv
// jtag host model driving the test access pins
`timescale 1ns/100ps
module jdp_host (
  output logic TCK,
  output logic TMS,
  output logic TDI,
  output logic TRST_N,
  input wire logic TDO
);
  // pins at rest, test reset held low from power up
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b1;
    TRST_N = 1'b0;
  end
  // one 125 ns tck period, tdo taken just before the rise
  task automatic step(input logic ms, input logic di, output logic dout);
    TMS = ms;
    TDI = di;
    #62.5;
    dout = TDO;
    TCK = 1'b1;
    #62.5;
    TCK = 1'b0;
  endtask
  // test reset pulse well past its minimum width
  task automatic test_reset();
    TRST_N = 1'b0;
    #150;
    TRST_N = 1'b1;
  endtask
  // five tms highs reach test-logic-reset, then idle
  task automatic reset_tap();
    logic b;
    repeat (5) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
  // idle, one scan of n bits, back to idle
  task automatic shift(input logic ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b1, b);
    if (ir) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
endmodule // jdp_host

// File: dv/jdp_checker.sv
// assertions on the jtag debug and id port
`timescale 1ns/100ps
module jdp_checker
  import jdp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic TRST_N,
  input wire logic TDO_OE_N,
  input wire logic DBG_WSTROBE,
  input wire logic [SEC_W-1:0] SECURITY,
  input wire logic DBG_PIN_EN,
  input wire logic DBG_PIN_DIR,
  input wire logic BREAKPOINT_HIT,
  input wire logic DEBUG_N_IN,
  input wire logic DEBUG_N_OE_N,
  input wire logic DEBUG_ENTER,
  input wire logic RST_N,
  input wire logic [BM_W-1:0] BOOT_MODE,
  input wire logic CORE_RESET_N,
  input wire logic PLL_RELOCK,
  input wire logic BOOT_START,
  input wire logic [BM_W-1:0] BOOT_MODE_SEL
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // inputs held long enough to pass the synchronisers, and the one-cycle boot pulse
  sequence s_trst_low;
    !TRST_N [*6];
  endsequence
  sequence s_pulled;
    (DBG_PIN_EN && !DBG_PIN_DIR && !SECURITY[SEC_DEBUG_OFF] && !DEBUG_N_IN) [*4];
  endsequence
  sequence s_boot;
    BOOT_START ##1 !BOOT_START;
  endsequence
  // sync pin drive request
  logic drv;
  assign drv = DBG_PIN_EN && DBG_PIN_DIR && BREAKPOINT_HIT && !SECURITY[SEC_DEBUG_OFF];
  AST_TAP_HELD: assert property (s_trst_low |-> TDO_OE_N && !DBG_WSTROBE)
    else $error("tap active under test reset");
  AST_SYNC_DRIVE: assert property (drv |=> !DEBUG_N_OE_N)
    else $error("sync pin not driven");
  AST_SYNC_FLOAT: assert property (!drv |=> DEBUG_N_OE_N)
    else $error("sync pin driven early");
  AST_SYNC_ENTER: assert property (s_pulled |-> DEBUG_ENTER)
    else $error("debug entry missed");
  AST_SYNC_IGNORE: assert property ((!DBG_PIN_EN || DBG_PIN_DIR || SECURITY[SEC_DEBUG_OFF])
    |=> !DEBUG_ENTER) else $error("debug entry not gated");
  AST_RST_HOLD: assert property (!RST_N [*5] |-> !CORE_RESET_N && !BOOT_START)
    else $error("core out of reset");
  AST_BOOT_AFTER_LOCK: assert property (BOOT_START |-> $past(PLL_RELOCK))
    else $error("boot without relock");
  AST_BOOT_PULSE: assert property ($rose(CORE_RESET_N) |-> s_boot)
    else $error("boot pulse wrong");
  AST_BOOT_MODE: assert property (BOOT_START |=> BOOT_MODE_SEL == BOOT_MODE)
    else $error("boot mode not latched");
  AST_STROBE: assert property (DBG_WSTROBE |=> !DBG_WSTROBE)
    else $error("write strobe too long");
  AST_SECURE: assert property (SECURITY[SEC_JTAG_OFF] [*2] |-> !DBG_WSTROBE)
    else $error("write while locked");
endmodule // jdp_checker
bind jdp_top jdp_checker jdp_checker_i (
  .CLK, .RST, .TRST_N, .TDO_OE_N, .DBG_WSTROBE, .SECURITY, .DBG_PIN_EN, .DBG_PIN_DIR,
  .BREAKPOINT_HIT, .DEBUG_N_IN, .DEBUG_N_OE_N, .DEBUG_ENTER, .RST_N, .BOOT_MODE,
  .CORE_RESET_N, .PLL_RELOCK, .BOOT_START, .BOOT_MODE_SEL);

// File: dv/jdp_top_bench.sv
// self-checking bench for the jtag debug and id port
`timescale 1ns/100ps
module jdp_top_bench;
  import jdp_pkg::*;
  localparam logic [3:0] VER = 4'h3; // arbitrary value
  localparam logic [15:0] PART = 16'hC3A5; // arbitrary value
  localparam logic [10:0] MFR = 11'h2B6; // arbitrary value
  localparam logic [15:0] REV = 16'h0042; // arbitrary value
  localparam logic [31:0] ID = {VER, PART, MFR, 1'b1};
  logic CLK = 1'b0, RST = 1'b1, DBG_PIN_EN = 1'b0, DBG_PIN_DIR = 1'b0, BREAKPOINT_HIT = 1'b0;
  logic RST_N = 1'b0, PLL_LOCK = 1'b0, ext_low = 1'b0, debug_line;
  logic TCK, TMS, TDI, TRST_N, TDO, TDO_OE_N, EXTEST_ON, DBG_WSTROBE, DEBUG_N_OUT, DEBUG_N_OE_N;
  logic DEBUG_ENTER, CORE_RESET_N, PLL_RELOCK, BOOT_START;
  logic [31:0] SECURITY = 32'h0, DBG_RDATA = 32'h0, DBG_WDATA, wdata;
  logic [7:0] PIN_IN = 8'h00, PIN_OUT;
  logic [1:0] BOOT_MODE = 2'h0, BOOT_MODE_SEL;
  logic [63:0] q;
  logic [31:0] secs [2] = '{32'h0, 32'hAD40_1234};
  logic [6:0] pins [6] = '{7'h62, 7'h70, 7'h76, 7'h4B, 7'h0A, 7'h4E};
  int n_fail = 0, num_checks = 0, n_strobe = 0, n_oe = 0;
  // clock and pulled-up sync line
  always #5 CLK = ~CLK;
  assign debug_line = !DEBUG_N_OE_N ? DEBUG_N_OUT : !ext_low;
  // count debug write strobes and driven tdo cycles, away from the launching edge
  always @(negedge CLK) begin
    if (DBG_WSTROBE === 1'b1) begin
      n_strobe++;
      wdata = DBG_WDATA;
    end
    if (TDO_OE_N === 1'b0) n_oe++;
  end
  jdp_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR), .SI_REVISION(REV)) jdp_top_i (
    .CLK, .RST, .TCK, .TMS, .TDI, .TRST_N, .TDO, .TDO_OE_N, .SECURITY, .PIN_IN, .PIN_OUT,
    .EXTEST_ON, .DBG_RDATA, .DBG_WDATA, .DBG_WSTROBE, .DBG_PIN_EN, .DBG_PIN_DIR,
    .BREAKPOINT_HIT, .DEBUG_N_IN(debug_line), .DEBUG_N_OUT, .DEBUG_N_OE_N, .DEBUG_ENTER,
    .RST_N, .PLL_LOCK, .BOOT_MODE, .CORE_RESET_N, .PLL_RELOCK, .BOOT_START, .BOOT_MODE_SEL);
  jdp_host jdp_host_i (.TCK, .TMS, .TDI, .TRST_N, .TDO);
  // compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // instruction scan, both taps capture 0001
  task automatic ir(input logic [3:0] bnd, input logic [3:0] chip);
    jdp_host_i.shift(1'b1, 8, {56'h0, bnd, chip}, q);
    check(q, 64'h11);
  endtask
  task automatic dr(input int n, input logic [63:0] d);
    jdp_host_i.shift(1'b0, n, d, q);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard
  initial begin
    #200_000;
    n_fail++;
    print_verdict();
  end
  // test sequence
  initial begin
    tick(6);
    RST = 1'b0;
    jdp_host_i.test_reset();
    jdp_host_i.reset_tap();
    dr(64, '1);
    check(q, {ID, ID});
    check(n_oe > 0, 1'b1);
    check(TDO_OE_N, 1'b1);
    $display("id chain done");
    foreach (secs[k]) begin
      tick(1);
      SECURITY = secs[k];
      ir(IR_BYPASS, IR_USERCODE);
      dr(33, '0);
      check(q, {32'h0, secs[k][31:22], 6'h00, REV});
    end
    $display("usercode done");
    tick(1);
    DBG_RDATA = 32'h5E17_C0A9;
    n_strobe = 0;
    ir(IR_BYPASS, IR_DEBUG);
    dr(33, 64'h1_9C3B_58E6);
    tick(4);
    check(q, {32'h0, DBG_RDATA});
    check(n_strobe, 1);
    check(wdata, 32'h9C3B_58E6);
    $display("debug access done");
    tick(1);
    PIN_IN = 8'hB4;
    ir(IR_SAMPLE, IR_BYPASS);
    dr(9, '0);
    check(q, {PIN_IN, 1'b0});
    ir(IR_EXTEST, IR_BYPASS);
    check(EXTEST_ON, 1'b1);
    dr(9, 64'h0D3);
    check(PIN_OUT, 8'h69);
    $display("boundary done");
    ir(IR_USERCODE, IR_USERCODE);
    jdp_host_i.test_reset();
    check(TDO_OE_N, 1'b1);
    jdp_host_i.step(1'b0, 1'b1, q[0]);
    dr(64, '1);
    check(q, {ID, ID});
    $display("test reset done");
    tick(1);
    SECURITY = 32'h0000_0001;
    jdp_host_i.reset_tap();
    dr(33, '0);
    check(q, {31'h0, ID, 1'b0});
    n_strobe = 0;
    ir(IR_BYPASS, IR_DEBUG);
    dr(2, '1);
    check(q, 64'h0);
    check(n_strobe, 0);
    $display("lock done");
    foreach (pins[k]) begin
      tick(1);
      {DBG_PIN_EN, DBG_PIN_DIR, BREAKPOINT_HIT, ext_low} = pins[k][6:3];
      SECURITY = {17'h0, pins[k][2], 14'h0};
      tick(6);
      check({DEBUG_N_OE_N, DEBUG_ENTER}, pins[k][1:0]);
    end
    check(DEBUG_N_OUT, 1'b0);
    $display("sync pin done");
    for (int m = 0; m < 4; m++) begin
      tick(1);
      RST_N = 1'b0;
      PLL_LOCK = 1'b0;
      BOOT_MODE = m[1:0];
      tick(12);
      check(CORE_RESET_N, 1'b0);
      RST_N = 1'b1;
      tick(8);
      check({PLL_RELOCK, CORE_RESET_N}, 2'b10);
      PLL_LOCK = 1'b1;
      repeat (20) begin
        tick(1);
        if (CORE_RESET_N === 1'b1) break;
      end
      tick(1);
      check({CORE_RESET_N, BOOT_MODE_SEL}, {1'b1, m[1:0]});
    end
    $display("boot done");
    print_verdict();
  end
endmodule // jdp_top_bench
